// File: pkg/usdp_pkg.sv
// Constants for the uart shadow data port
//
// Notes on behaviour
// [R1] Sixteen word-spaced shadow words alias receive buffer and transmit holding, low byte.
// [R2] Received bits come from serial input, or infrared input in infrared mode.
// [R3] Transmit bits go to serial output, or active-low infrared output in infrared mode.
// [R4] Software trusts receive data only while the data ready flag is set.
// [R5] FIFOs off: new character overwrites unread byte and flags overrun.
// [R6] FIFOs on: reading the receive alias returns the receive FIFO head.
// [R7] Receive FIFO full: incoming character dropped, contents kept, overrun flagged.
// [R8] Software writes transmit data only while the holding empty flag is set.
// [R9] FIFOs off: one write clears the holding empty flag.
// [R10] FIFOs off: further writes before empty sets again overwrite pending byte.
// [R11] FIFOs on: sixteen characters accepted before the transmit FIFO is full.
// [R12] Write while transmit FIFO full is discarded, contents unchanged.
// [R13] Upper reserved byte reads zero; writes to it have no effect.
package usdp_pkg;
    localparam int ADDR_W = 32;
    localparam logic [31:0] SHADOW_BASE = 32'h50001130;
    localparam int SHADOW_COUNT = 16;
    localparam logic [31:0] SHADOW_LAST = 32'h5000116C;
    localparam logic [31:0] SHADOW_DATA_2 = 32'h50001138;
    localparam logic [31:0] SHADOW_DATA_3 = 32'h5000113C;
    // Own control and status registers
    localparam logic [31:0] CTRL_ADDR = 32'h50001180;
    localparam logic [31:0] STATUS_ADDR = 32'h50001184;
    localparam int CTRL_FIFO_EN_BIT = 0;
    localparam int CTRL_IR_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int STAT_DATA_READY_BIT = 0;
    localparam int STAT_OVERRUN_BIT = 1;
    localparam int STAT_HOLD_EMPTY_BIT = 5;
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam int BAUD_DIV = 16;
    localparam int BAUD_W = 5;
    localparam int HALF_BIT = 8;
    localparam int IR_PULSE_TICKS = 3;
    localparam int FRAME_BITS = 10;
    typedef enum logic [1:0] {USDP_IDLE, USDP_START, USDP_DATA, USDP_STOP} usdp_line_e;
endpackage

// File: src/usdp_rx_line.sv
// Serial receiver for the shadow data port, 8N1 with an oversample enable, BAUD_DIV pulses per bit
`timescale 1ns/100ps
module usdp_rx_line
    import usdp_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic bit_tick_in,
    input wire logic line_in,
    output logic [7:0] byte_out,
    output logic byte_valid_out
);
    usdp_line_e state_q;
    logic [BAUD_W-1:0] tick_cnt_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    wire mid_bit = bit_tick_in && (tick_cnt_q == BAUD_W'(HALF_BIT - 1));
    wire full_bit = bit_tick_in && (tick_cnt_q == BAUD_W'(BAUD_DIV - 1));

    // Start detect, centre sampling and stop check
    always_ff @(posedge clk_sys_in) begin
        byte_valid_out <= 1'b0;
        if (!reset_n_in) begin
            state_q <= USDP_IDLE;
            tick_cnt_q <= '0;
            bit_cnt_q <= '0;
            shift_q <= '0;
            byte_out <= '0;
        end else if (bit_tick_in) begin
            tick_cnt_q <= full_bit ? '0 : tick_cnt_q + 1'b1;
            unique case (state_q)
                USDP_IDLE: begin
                    tick_cnt_q <= '0;
                    if (!line_in) state_q <= USDP_START;
                end
                USDP_START: begin
                    if (mid_bit) begin
                        tick_cnt_q <= '0;
                        bit_cnt_q <= '0;
                        state_q <= line_in ? USDP_IDLE : USDP_DATA;
                    end
                end
                USDP_DATA: begin
                    if (full_bit) begin
                        shift_q <= {line_in, shift_q[7:1]};
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                        if (bit_cnt_q == 4'h7) state_q <= USDP_STOP;
                    end
                end
                USDP_STOP: begin
                    if (full_bit) begin
                        state_q <= USDP_IDLE;
                        if (line_in) begin
                            byte_out <= shift_q;
                            byte_valid_out <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end
endmodule // usdp_rx_line

// File: src/usdp_shadow_port.sv
// Shadow data port: register slave, receive buffer or FIFO, transmit holding or FIFO
`timescale 1ns/100ps
module usdp_shadow_port
    import usdp_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic serial_in,
    input wire logic ir_in,
    output logic serial_out,
    output logic ir_n_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic logic is_shadow(input logic [ADDR_W-1:0] a);
        return (a >= SHADOW_BASE) && (a <= SHADOW_LAST) && (a[1:0] == 2'h0);
    endfunction

    // [R1] shadow alias decode
    wire shadow_sel = is_shadow(addr_in);
    wire shadow_wr = wr_in && shadow_sel;
    wire shadow_rd = rd_in && shadow_sel;
    wire ctrl_wr = wr_in && (addr_in == CTRL_ADDR);

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and bit-rate divider
    logic ser_m_q, ser_s_q, ir_m_q, ir_s_q;
    logic [BAUD_W-1:0] baud_q;
    logic tick_q;
    logic [1:0] ctrl_q;
    wire fifo_en = ctrl_q[CTRL_FIFO_EN_BIT];
    wire ir_mode = ctrl_q[CTRL_IR_BIT];

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            {ser_m_q, ser_s_q} <= 2'h3;
            {ir_m_q, ir_s_q} <= 2'h0;
        end else begin
            ser_m_q <= serial_in;
            ser_s_q <= ser_m_q;
            ir_m_q <= ir_in;
            ir_s_q <= ir_m_q;
        end
    end

    // Oversample enable: one pulse per BAUD_DIV-th of a bit
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            baud_q <= '0;
            tick_q <= 1'b0;
        end else begin
            baud_q <= (baud_q == BAUD_W'(BAUD_DIV - 1)) ? '0 : baud_q + 1'b1;
            tick_q <= (baud_q == BAUD_W'(BAUD_DIV - 1));
        end
    end

    // [R2] line select by mode; infrared pulses high mean a zero bit
    // Infrared pulse is short, so stretch it past the receiver's mid-bit sample
    logic [BAUD_W-1:0] ir_hold_q;
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            ir_hold_q <= '0;
        end else if (ir_s_q) begin
            ir_hold_q <= BAUD_W'(HALF_BIT);
        end else if (tick_q && (ir_hold_q != '0)) begin
            ir_hold_q <= ir_hold_q - 1'b1;
        end
    end
    wire ir_low = ir_s_q || (ir_hold_q != '0);
    wire rx_line = ir_mode ? !ir_low : ser_s_q;
    logic [7:0] rx_byte;
    logic rx_valid;

    usdp_rx_line u_rx (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .bit_tick_in(tick_q),
        .line_in(rx_line),
        .byte_out(rx_byte),
        .byte_valid_out(rx_valid)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Receive buffer and FIFO
    logic [7:0] rx_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] rx_rp_q, rx_wp_q;
    logic [CNT_W-1:0] rx_cnt_q;
    logic overrun_q;
    wire rx_empty = (rx_cnt_q == '0);
    wire rx_full = fifo_en ? (rx_cnt_q == CNT_W'(FIFO_DEPTH)) : (rx_cnt_q != '0);
    wire rx_pop = shadow_rd && !rx_empty;
    // [R7] drop on full only in FIFO mode; buffer mode overwrites
    wire rx_push = rx_valid && (!fifo_en || !rx_full || rx_pop);
    wire rx_ovr = rx_valid && rx_full && !rx_pop;

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in || ctrl_wr) begin
            rx_rp_q <= '0;
            rx_wp_q <= '0;
            rx_cnt_q <= '0;
        end else if (!fifo_en) begin
            // [R5] single buffer overwritten
            if (rx_valid) begin
                rx_mem[0] <= rx_byte;
                rx_cnt_q <= CNT_W'(1);
            end else if (rx_pop) begin
                rx_cnt_q <= '0;
            end
            rx_rp_q <= '0;
            rx_wp_q <= '0;
        end else begin
            if (rx_push) begin
                rx_mem[rx_wp_q] <= rx_byte;
                rx_wp_q <= rx_wp_q + 1'b1;
            end
            if (rx_pop) rx_rp_q <= rx_rp_q + 1'b1;
            rx_cnt_q <= rx_cnt_q + CNT_W'(rx_push) - CNT_W'(rx_pop);
        end
    end

    // Overrun is sticky; a status read clears it, a new overrun wins
    wire stat_rd = rd_in && (addr_in == STATUS_ADDR);
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) overrun_q <= 1'b0;
        else if (rx_ovr) overrun_q <= 1'b1;
        else if (stat_rd) overrun_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit holding and FIFO
    logic [7:0] tx_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] tx_rp_q, tx_wp_q;
    logic [CNT_W-1:0] tx_cnt_q;
    usdp_line_e tx_state_q;
    logic [FRAME_BITS-1:0] tx_shift_q;
    logic [3:0] tx_bits_q;
    logic [BAUD_W-1:0] tx_tick_q;
    wire tx_full = fifo_en ? (tx_cnt_q == CNT_W'(FIFO_DEPTH)) : 1'b0;
    wire hold_empty = (tx_cnt_q == '0);
    wire tx_load = (tx_state_q == USDP_IDLE) && !hold_empty;
    // [R12] full FIFO drops the write
    wire tx_push = shadow_wr && !tx_full;

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in || ctrl_wr) begin
            tx_rp_q <= '0;
            tx_wp_q <= '0;
            tx_cnt_q <= '0;
        end else if (!fifo_en) begin
            // [R9] [R10] one holding byte, later writes overwrite it
            if (tx_push) tx_mem[0] <= wdata_in[7:0];
            if (tx_push) tx_cnt_q <= CNT_W'(1);
            else if (tx_load) tx_cnt_q <= '0;
        end else begin
            // [R11] up to sixteen queued
            if (tx_push) begin
                tx_mem[tx_wp_q] <= wdata_in[7:0];
                tx_wp_q <= tx_wp_q + 1'b1;
            end
            if (tx_load) tx_rp_q <= tx_rp_q + 1'b1;
            tx_cnt_q <= tx_cnt_q + CNT_W'(tx_push) - CNT_W'(tx_load);
        end
    end

    // Transmit shifter, one bit per BAUD_DIV ticks, LSB first
    wire [7:0] tx_head = fifo_en ? tx_mem[tx_rp_q] : tx_mem[0];
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            tx_state_q <= USDP_IDLE;
            tx_shift_q <= '1;
            tx_bits_q <= '0;
            tx_tick_q <= '0;
        end else if (tx_load) begin
            tx_state_q <= USDP_DATA;
            tx_shift_q <= {1'b1, tx_head, 1'b0};
            tx_bits_q <= '0;
            tx_tick_q <= '0;
        end else if (tx_state_q != USDP_IDLE && tick_q) begin
            tx_tick_q <= tx_tick_q + 1'b1;
            if (tx_tick_q == BAUD_W'(BAUD_DIV - 1)) begin
                tx_tick_q <= '0;
                tx_shift_q <= {1'b1, tx_shift_q[FRAME_BITS-1:1]};
                tx_bits_q <= tx_bits_q + 1'b1;
                if (tx_bits_q == 4'(FRAME_BITS - 1)) tx_state_q <= USDP_IDLE;
            end
        end
    end

    // [R3] output steering; infrared pulse in the first part of a zero bit
    wire ir_pulse = !tx_shift_q[0] && (tx_tick_q < BAUD_W'(IR_PULSE_TICKS))
                  && (tx_state_q != USDP_IDLE);
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            serial_out <= 1'b1;
            ir_n_out <= 1'b1;
        end else begin
            serial_out <= ir_mode ? 1'b1 : tx_shift_q[0];
            ir_n_out <= ir_mode ? !ir_pulse : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control register and read data
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) ctrl_q <= CTRL_RESET;
        else if (ctrl_wr) ctrl_q <= wdata_in[1:0];
    end

    // [R6] [R13] head of receive store, upper bits zero
    // Empty store reads zero, so no unwritten memory word ever reaches the bus
    wire [7:0] rx_head = rx_empty ? 8'h00 : fifo_en ? rx_mem[rx_rp_q] : rx_mem[0];
    wire [31:0] stat_word = (32'(!rx_empty) << STAT_DATA_READY_BIT)
                          | (32'(overrun_q) << STAT_OVERRUN_BIT)
                          | (32'(hold_empty) << STAT_HOLD_EMPTY_BIT);
    wire [31:0] rd_mux = shadow_sel ? {24'h000000, rx_head}
                       : (addr_in == CTRL_ADDR) ? {30'h0, ctrl_q}
                       : (addr_in == STATUS_ADDR) ? stat_word : 32'h00000000;
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) rdata_out <= '0;
        else if (rd_in) rdata_out <= rd_mux;
        else rdata_out <= '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    status_rd_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in) // [R4]
        stat_rd && !rx_empty |=> rdata_out[STAT_DATA_READY_BIT]) else $error("data ready lost");
    upper_zero_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in) // [R13]
        shadow_rd |=> rdata_out[31:8] == 24'h0) else $error("upper byte not zero");
    rx_drop_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in || ctrl_wr) // [R7]
        fifo_en && rx_ovr |=> overrun_q && rx_cnt_q == CNT_W'(FIFO_DEPTH)) else $error("rx drop");
    rx_over_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in || ctrl_wr) // [R5]
        !fifo_en && rx_valid |=> rx_mem[0] == $past(rx_byte)) else $error("no overwrite");
    tx_holding_empty_flag_clr_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in || ctrl_wr) // [R9]
        !fifo_en && shadow_wr |=> !hold_empty) else $error("empty flag kept");
    thr_ovw_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in || ctrl_wr) // [R10]
        !fifo_en && shadow_wr |=> tx_mem[0] == $past(wdata_in[7:0])) else $error("no tx overwrite");
    tx_depth_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in) // [R11]
        tx_cnt_q <= CNT_W'(FIFO_DEPTH)) else $error("tx fifo overflow");
    tx_drop_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in || ctrl_wr) // [R12]
        fifo_en && shadow_wr && tx_full && !tx_load |=> $stable(tx_cnt_q)) else $error("tx drop");
    rx_pop_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in) // [R6]
        fifo_en && rx_pop |=> rdata_out[7:0] == $past(rx_head)) else $error("bad head");
    ir_idle_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in) // [R3]
        !ir_mode |=> ir_n_out) else $error("ir driven in serial mode");
    rd_idle_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in) // [R1]
        !rd_in |=> rdata_out == 32'h00000000) else $error("read data not cleared");
    ser_idle_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in) // [R3]
        ir_mode |=> serial_out) else $error("serial driven in infrared mode");
    cv_ir_rx: cover property (@(posedge clk_sys_in) ir_mode && rx_valid);
    cv_rx_ovr: cover property (@(posedge clk_sys_in) rx_ovr);
    cv_tx_full: cover property (@(posedge clk_sys_in) tx_full);
    cv_ir_tx: cover property (@(posedge clk_sys_in) !ir_n_out);
endmodule // usdp_shadow_port

// File: testbench/uart_shadow_data_port_bench.sv
// Self-checking bench for the uart shadow data port
`timescale 1ns/100ps
module uart_shadow_data_port_bench
    import usdp_pkg::*;
;
    logic clk_sys_in, reset_n_in, wr_in, rd_in, serial_in, ir_in, serial_out, ir_n_out;
    logic [ADDR_W-1:0] addr_in;
    logic [31:0] wdata_in, rdata_out;
    logic [8:0] frm;
    logic [7:0] tx_b [18];
    logic [7:0] rx_b [17];
    int num_errors, checks, bad;
    usdp_shadow_port uut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .serial_in(serial_in), .ir_in(ir_in), .serial_out(serial_out), .ir_n_out(ir_n_out));
    usdp_peer_model peer (.clk_sys_in(clk_sys_in), .tx_line_in(serial_out),
        .ir_tx_n_in(ir_n_out), .rx_line_out(serial_in), .ir_rx_out(ir_in));
    ////////////////////////////////////////////////////////////////
    // 250 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    task automatic summarize();
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        checks++;
        if (act !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp);
        end
    endtask
    // Bus master: write strobe held across edges, dropped by idle or the next read; read strobe lasts one cycle
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        wr_in <= 1'b1;
        rd_in <= 1'b0;
        addr_in <= a;
        wdata_in <= d;
    endtask
    task automatic idle();
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk_sys_in);
        rd_in <= 1'b1;
        wr_in <= 1'b0;
        addr_in <= a;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, exp);
    endtask
    function automatic logic [31:0] stat(input logic rdy, input logic ovr, input logic emp);
        logic [31:0] s;
        s = 32'h0;
        s[STAT_DATA_READY_BIT] = rdy;
        s[STAT_OVERRUN_BIT] = ovr;
        s[STAT_HOLD_EMPTY_BIT] = emp;
        return s;
    endfunction
    function automatic logic [31:0] alias_addr(input int idx);
        return SHADOW_BASE + 32'(idx % SHADOW_COUNT) * 32'h4;
    endfunction
    function automatic logic [31:0] frame_of(input logic [7:0] b);
        return {23'h0, 1'b1, b};
    endfunction
    ////////////////////////////////////////////////////////////////
    // Watchdog cuts a hang short
    initial begin
        repeat (90000) @(posedge clk_sys_in);
        num_errors++;
        summarize();
    end
    // Main sequence
    initial begin
        reset_n_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 32'h0;
        wdata_in = 32'h0;
        num_errors = 0;
        checks = 0;
        void'($urandom(81));
        foreach (tx_b[i]) tx_b[i] = 8'($urandom);
        foreach (rx_b[i]) rx_b[i] = 8'($urandom);
        repeat (8) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        rd(SHADOW_DATA_2, 32'h0);
        rd(SHADOW_DATA_3, 32'h0);
        rd(STATUS_ADDR, stat(1'b0, 1'b0, 1'b1));
        rd(SHADOW_LAST + 32'h4, 32'h0);
        chk(32'({serial_out, ir_n_out}), 32'h3);
        $display("reset test done");
        // Buffer mode transmit: one write clears empty, a second pending write is replaced
        fork
            begin
                peer.recv_byte(1'b0, frm);
                chk(32'(frm), frame_of(tx_b[0]));
                peer.recv_byte(1'b0, frm);
                chk(32'(frm), frame_of(tx_b[2]));
            end
            begin
                wr(alias_addr(5), {24'hA5A5A5, tx_b[0]});
                idle();
                repeat (20) @(posedge clk_sys_in);
                wr(alias_addr(15), {24'h0, tx_b[1]});
                rd(STATUS_ADDR, stat(1'b0, 1'b0, 1'b0));
                wr(SHADOW_DATA_3, {24'h0, tx_b[2]});
                idle();
            end
        join
        repeat (200) @(posedge clk_sys_in);
        rd(STATUS_ADDR, stat(1'b0, 1'b0, 1'b1));
        $display("buffer transmit test done");
        // Buffer mode receive, then overrun by a second unread byte
        peer.send_byte(rx_b[0], 1'b0);
        repeat (40) @(posedge clk_sys_in);
        rd(STATUS_ADDR, stat(1'b1, 1'b0, 1'b1));
        rd(alias_addr($urandom_range(15)), {24'h0, rx_b[0]});
        rd(STATUS_ADDR, stat(1'b0, 1'b0, 1'b1));
        peer.send_byte(rx_b[1], 1'b0);
        peer.send_byte(rx_b[2], 1'b0);
        repeat (40) @(posedge clk_sys_in);
        rd(STATUS_ADDR, stat(1'b1, 1'b1, 1'b1));
        rd(SHADOW_DATA_2, {24'h0, rx_b[2]});
        rd(STATUS_ADDR, stat(1'b0, 1'b0, 1'b1));
        $display("buffer receive test done");
        // Infrared mode both ways; serial output must stay idle
        wr(CTRL_ADDR, 32'h2);
        idle();
        bad = 0;
        fork
            peer.send_byte(rx_b[3], 1'b1);
            begin
                peer.recv_byte(1'b1, frm);
                chk(32'(frm), frame_of(tx_b[3]));
            end
            begin
                wr(alias_addr(9), {24'h0, tx_b[3]});
                idle();
            end
            repeat (2600) begin
                @(posedge clk_sys_in);
                if (serial_out !== 1'b1) bad++;
            end
        join
        chk(32'(bad), 32'h0);
        repeat (40) @(posedge clk_sys_in);
        rd(alias_addr(0), {24'h0, rx_b[3]});
        $display("infrared test done");
        // FIFO mode: fill both FIFOs past full while the peer streams
        wr(CTRL_ADDR, 32'h1);
        idle();
        fork
            for (int i = 0; i < 17; i++) peer.send_byte(rx_b[i], 1'b0);
            begin
                for (int i = 0; i < 18; i++) wr(alias_addr(i), {24'h0, tx_b[i]});
                rd(STATUS_ADDR, stat(1'b0, 1'b0, 1'b0));
            end
            for (int i = 0; i < 17; i++) begin
                peer.recv_byte(1'b0, frm);
                chk(32'(frm), frame_of(tx_b[i]));
            end
        join
        bad = 0;
        repeat (400) begin
            @(posedge clk_sys_in);
            if (serial_out !== 1'b1) bad++;
        end
        chk(32'(bad), 32'h0);
        rd(STATUS_ADDR, stat(1'b1, 1'b1, 1'b1));
        for (int i = 0; i < 16; i++) rd(alias_addr(i + 3), {24'h0, rx_b[i]});
        rd(STATUS_ADDR, stat(1'b0, 1'b0, 1'b1));
        $display("fifo test done");
        summarize();
    end
endmodule // uart_shadow_data_port_bench

// File: testbench/usdp_peer_model.sv
// Remote serial and infrared peer that talks to the shadow data port
`timescale 1ns/100ps
module usdp_peer_model
    import usdp_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic tx_line_in,
    input wire logic ir_tx_n_in,
    output logic rx_line_out,
    output logic ir_rx_out
);
    localparam int BIT_CLKS = BAUD_DIV * 16;
    localparam int PULSE_CLKS = 3 * BAUD_DIV;
    ////////////////////////////////////////////////////////////////
    // Both lines idle: serial high, infrared dark
    initial begin
        rx_line_out = 1'b1;
        ir_rx_out = 1'b0;
    end
    // Send one 8N1 frame, LSB first; a zero bit is a short light pulse in infrared
    task automatic send_byte(input logic [7:0] data, input logic ir_mode);
        logic [9:0] frame;
        frame = {1'b1, data, 1'b0};
        for (int i = 0; i < FRAME_BITS; i++) begin
            @(posedge clk_sys_in);
            if (ir_mode) begin
                ir_rx_out <= ~frame[i];
                repeat (PULSE_CLKS) @(posedge clk_sys_in);
                ir_rx_out <= 1'b0;
                repeat (BIT_CLKS - PULSE_CLKS - 1) @(posedge clk_sys_in);
            end else begin
                rx_line_out <= frame[i];
                repeat (BIT_CLKS - 1) @(posedge clk_sys_in);
            end
        end
    endtask
    // Take one frame; returns the stop bit above the eight data bits
    task automatic recv_byte(input logic ir_mode, output logic [8:0] frame_out);
        if (ir_mode) begin
            @(negedge ir_tx_n_in);
        end else begin
            @(negedge tx_line_in);
        end
        repeat (ir_mode ? PULSE_CLKS / 2 : BIT_CLKS / 2) @(posedge clk_sys_in);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CLKS) @(posedge clk_sys_in);
            frame_out[i] = ir_mode ? ir_tx_n_in : tx_line_in;
        end
    endtask
endmodule // usdp_peer_model
